// File: hdl/lap_pkg.sv
package lap_pkg;

   // Register word addresses on the plain register port.
   localparam logic [3:0] ADDR_MODE      = 4'h0;
   localparam logic [3:0] ADDR_EXT       = 4'h1;
   localparam logic [3:0] ADDR_RANGE     = 4'h2;
   localparam logic [3:0] ADDR_ACCEL     = 4'h3;
   localparam logic [3:0] ADDR_DECEL     = 4'h4;
   localparam logic [3:0] ADDR_START     = 4'h5;
   localparam logic [3:0] ADDR_DRIVE     = 4'h6;
   localparam logic [3:0] ADDR_PULSES    = 4'h7;
   localparam logic [3:0] ADDR_CMD       = 4'h8;
   localparam logic [3:0] ADDR_STATUS    = 4'h9;
   localparam logic [3:0] ADDR_SPEED     = 4'hA;
   localparam logic [3:0] ADDR_EMITTED   = 4'hB;

   // Field positions.
   localparam int MODE_MANUAL_BIT = 0;
   localparam int MODE_SEP_BIT    = 1;
   localparam int MODE_CURVE_BIT  = 2;
   localparam int EXT_TRI_BIT     = 3;
   localparam int CMD_FIXED_BIT   = 0;
   localparam int CMD_CONT_BIT    = 1;
   localparam int CMD_DSTOP_BIT   = 2;
   localparam int CMD_SSTOP_BIT   = 3;

   // Values after reset.
   localparam logic [2:0]  MODE_RST   = 3'h0;
   localparam logic        TRI_RST    = 1'b0;
   localparam logic [31:0] RANGE_RST  = 32'h007A_1200;
   localparam logic [15:0] PARAM_RST  = 16'h0000;
   localparam logic [31:0] COUNT_RST  = 32'h0000_0000;

   // Rate arithmetic: clock 20 MHz, range reference 8,000,000, accel unit 125.
   localparam int          RATE_W     = 48;
   localparam logic [47:0] CLK_HZ     = 48'h0000_0131_2D00;
   localparam logic [47:0] RANGE_REF  = 48'h0000_007A_1200;
   localparam logic [47:0] ACCEL_UNIT = 48'h0000_0000_007D;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ACCEL = 4'b0010,
      ST_CONST = 4'b0100,
      ST_DECEL = 4'b1000
   } lap_state_e;

endpackage

// File: hdl/lap_rate_if.sv
`timescale 1ns/10ps
interface lap_rate_if;
   import lap_pkg::*;
   logic              clear;
   logic [RATE_W-1:0] incr;
   logic [RATE_W-1:0] modulus;
   logic              tick;
   modport owner (output clear, output incr, output modulus, input tick);
   modport acc   (input clear, input incr, input modulus, output tick);
endinterface // lap_rate_if

// File: hdl/lap_rate_acc.sv
`timescale 1ns/10ps
module lap_rate_acc
   import lap_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic reset_i,
   lap_rate_if.acc   rate
);

   logic [RATE_W-1:0] acc_r;
   logic [RATE_W:0]   sum;
   logic              tick_r;

   assign sum = {1'b0, acc_r} + {1'b0, rate.incr};
   assign rate.tick = tick_r;

   // Fractional accumulator: one tick each time the sum passes the modulus.
   always_ff @(posedge clk_i) begin
      if (reset_i || rate.clear) begin
         acc_r  <= '0;
         tick_r <= 1'b0;
      end else if (sum >= {1'b0, rate.modulus}) begin
         acc_r  <= RATE_W'(sum - {1'b0, rate.modulus});
         tick_r <= 1'b1;
      end else begin
         acc_r  <= sum[RATE_W-1:0];
         tick_r <= 1'b0;
      end
   end

endmodule // lap_rate_acc

// File: hdl/lap_profile_gen.sv
`timescale 1ns/10ps
// Behaviour
// - Accelerate from start rate in a straight line at the programmed slope.
// - Symmetric fixed drive: decelerate once remaining pulses drop below acceleration pulses.
// - Decelerate linearly to start rate; end when all requested pulses are out.
// - Decelerating stop or short count turns acceleration straight into deceleration.
// - Symmetric mode uses the acceleration value for deceleration too.
// - Triangle prevention holds speed once accel plus decel pulses exceed half.
// - Triangle prevention is off after reset; host sets extension bit three.
// - Non-symmetric drive computes its deceleration point internally from count and rates.
// - Separate-deceleration bit makes deceleration use the deceleration parameter.
// - Real acceleration equals parameter times 125 times the speed multiple.
// - Multiple comes from range; real rate is speed times multiple.
// - Drive speed at or below start rate gives constant-speed drive.
// - Continuous drive emits pulses until a stop command, with no limit.
module lap_profile_gen
   import lap_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   output logic             drive_pulse_o,
   output logic             busy_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations and helpers.

   logic [2:0]  axis_mode_register_r;
   logic        triangle_prevent_enable_r;
   logic [31:0] range_r;
   logic [15:0] accel_r;
   logic [15:0] decel_r;
   logic [15:0] start_rate_r;
   logic [15:0] drive_speed_r;
   logic [31:0] pulse_cnt_r;
   logic [15:0] speed_r;
   logic [31:0] remain_r;
   logic [31:0] acc_pulses_r;
   logic [31:0] emitted_r;
   logic        cont_r;
   logic        stop_req_r;
   logic [31:0] rdata_r;
   logic        pulse_r;
   logic        busy_r;
   lap_state_e  state_r;
   lap_state_e  state_nxt;

   logic        cmd_wr;
   logic        start_fixed;
   logic        start_cont;
   logic        dstop;
   logic        sstop;
   logic        running;
   logic        ramp_tick;
   logic        pulse_tick;
   logic        last_pulse;
   logic        auto_dec;
   logic        tri_hold;
   logic        top_reached;
   logic        manual_decel_select;
   logic        separate_decel_enable;
   logic [15:0] dec_rate;

   lap_rate_if ramp ();
   lap_rate_if pgen ();

   lap_rate_acc u_ramp (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .rate    (ramp.acc)
   );

   lap_rate_acc u_pgen (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .rate    (pgen.acc)
   );

   // True when remaining pulses, slowed at rate d, no longer cover accel pulses at rate a.
   function automatic logic decel_due(input logic [31:0] remain, input logic [31:0] accp,
                                      input logic [15:0] a, input logic [15:0] d);
      decel_due = ({16'h0000, remain} * {32'h0000_0000, d}) <
                  ({16'h0000, accp} * {32'h0000_0000, a});
   endfunction

   // True when accel pulses plus the matching decel pulses exceed half of the total.
   function automatic logic tri_due(input logic [31:0] accp, input logic [31:0] total,
                                    input logic [15:0] a, input logic [15:0] d);
      logic [55:0] lhs;
      logic [55:0] rhs;
      lhs = {23'h00_0000, accp, 1'b0} * {39'h00_0000_0000, ({1'b0, a} + {1'b0, d})};
      rhs = {24'h00_0000, total} * {40'h00_0000_0000, d};
      tri_due = lhs > rhs;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode and rate sources.

   assign cmd_wr      = reg_wr_i && (reg_addr_i == ADDR_CMD);
   assign running     = (state_r != ST_IDLE);
   assign start_fixed = cmd_wr && reg_wdata_i[CMD_FIXED_BIT] && !running
                        && (pulse_cnt_r != COUNT_RST);
   assign start_cont  = cmd_wr && reg_wdata_i[CMD_CONT_BIT] && !running
                        && !reg_wdata_i[CMD_FIXED_BIT];
   assign dstop       = cmd_wr && reg_wdata_i[CMD_DSTOP_BIT] && running;
   assign sstop       = cmd_wr && reg_wdata_i[CMD_SSTOP_BIT] && running;
   assign ramp_tick   = ramp.tick;
   assign pulse_tick  = pgen.tick && running;
   assign last_pulse  = pulse_tick && !cont_r && (remain_r == 32'h0000_0001);
   assign top_reached = ({1'b0, speed_r} + 17'h0_0001) >= {1'b0, drive_speed_r};

   assign manual_decel_select   = axis_mode_register_r[MODE_MANUAL_BIT];
   assign separate_decel_enable = axis_mode_register_r[MODE_SEP_BIT];
   assign dec_rate = separate_decel_enable ? decel_r : accel_r;

   assign auto_dec = !cont_r && !manual_decel_select
                     && decel_due(remain_r, acc_pulses_r, accel_r, dec_rate);
   assign tri_hold = triangle_prevent_enable_r && !cont_r
                     && tri_due(acc_pulses_r, pulse_cnt_r, accel_r, dec_rate);

   assign ramp.clear   = !((state_r == ST_ACCEL) || (state_r == ST_DECEL));
   assign ramp.incr    = ((state_r == ST_DECEL) ? {32'h0000_0000, dec_rate}
                                                : {32'h0000_0000, accel_r}) * ACCEL_UNIT;
   assign ramp.modulus = CLK_HZ;
   assign pgen.clear   = !running;
   assign pgen.incr    = {32'h0000_0000, speed_r} * RANGE_REF;
   assign pgen.modulus = {16'h0000, range_r} * CLK_HZ;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers written by software.

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         axis_mode_register_r      <= MODE_RST;
         triangle_prevent_enable_r <= TRI_RST;
         range_r                   <= RANGE_RST;
         accel_r                   <= PARAM_RST;
         decel_r                   <= PARAM_RST;
         start_rate_r              <= PARAM_RST;
         drive_speed_r             <= PARAM_RST;
         pulse_cnt_r               <= COUNT_RST;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            ADDR_MODE:   axis_mode_register_r      <= reg_wdata_i[2:0];
            ADDR_EXT:    triangle_prevent_enable_r <= reg_wdata_i[EXT_TRI_BIT];
            ADDR_RANGE:  range_r                   <= reg_wdata_i;
            ADDR_ACCEL:  accel_r                   <= reg_wdata_i[15:0];
            ADDR_DECEL:  decel_r                   <= reg_wdata_i[15:0];
            ADDR_START:  start_rate_r              <= reg_wdata_i[15:0];
            ADDR_DRIVE:  drive_speed_r             <= reg_wdata_i[15:0];
            ADDR_PULSES: pulse_cnt_r               <= reg_wdata_i;
            default:     ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Profile state machine.

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            // constant speed when drive speed is not above start rate
            if (start_fixed || start_cont) begin
               state_nxt = (drive_speed_r <= start_rate_r) ? ST_CONST : ST_ACCEL;
            end
         end
         ST_ACCEL: begin
            if (sstop || last_pulse) begin
               state_nxt = ST_IDLE;
            end else if (dstop || auto_dec) begin
               state_nxt = ST_DECEL;
            end else if ((ramp_tick && top_reached) || tri_hold) begin
               state_nxt = ST_CONST;
            end
         end
         ST_CONST: begin
            if (sstop || last_pulse) begin
               state_nxt = ST_IDLE;
            end else if (dstop || auto_dec) begin
               state_nxt = ST_DECEL;
            end
         end
         ST_DECEL: begin
            // end at last pulse or at start rate after a stop
            if (sstop || last_pulse || (stop_req_r && (speed_r <= start_rate_r))) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cont_r     <= 1'b0;
         stop_req_r <= 1'b0;
      end else if (start_fixed || start_cont) begin
         cont_r     <= start_cont;
         stop_req_r <= 1'b0;
      end else if (dstop) begin
         stop_req_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Speed ramp.

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         speed_r <= PARAM_RST;
      end else if (start_fixed || start_cont) begin
         speed_r <= start_rate_r;
      end else if ((state_r == ST_ACCEL) && (state_nxt == ST_ACCEL) && ramp_tick) begin
         speed_r <= top_reached ? drive_speed_r : speed_r + 16'h0001;
      end else if ((state_r == ST_ACCEL) && ramp_tick && top_reached) begin
         speed_r <= drive_speed_r;
      end else if ((state_r == ST_DECEL) && ramp_tick && (speed_r > start_rate_r)) begin
         // linear fall, floor at start rate
         speed_r <= speed_r - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pulse counting and outputs.

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         remain_r     <= COUNT_RST;
         acc_pulses_r <= COUNT_RST;
         emitted_r    <= COUNT_RST;
      end else if (start_fixed || start_cont) begin
         remain_r     <= pulse_cnt_r;
         acc_pulses_r <= COUNT_RST;
         emitted_r    <= COUNT_RST;
      end else if (pulse_tick) begin
         if (!cont_r) begin
            remain_r <= remain_r - 32'h0000_0001;
         end
         if (state_r == ST_ACCEL) begin
            acc_pulses_r <= acc_pulses_r + 32'h0000_0001;
         end
         emitted_r <= emitted_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pulse_r <= 1'b0;
         busy_r  <= 1'b0;
      end else begin
         pulse_r <= pulse_tick;
         busy_r  <= (state_nxt != ST_IDLE);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i || !reg_rd_i) begin
         rdata_r <= COUNT_RST;
      end else begin
         case (reg_addr_i)
            ADDR_MODE:    rdata_r <= {29'h0000_0000, axis_mode_register_r};
            ADDR_EXT:     rdata_r <= {28'h000_0000, triangle_prevent_enable_r, 3'h0};
            ADDR_RANGE:   rdata_r <= range_r;
            ADDR_ACCEL:   rdata_r <= {16'h0000, accel_r};
            ADDR_DECEL:   rdata_r <= {16'h0000, decel_r};
            ADDR_START:   rdata_r <= {16'h0000, start_rate_r};
            ADDR_DRIVE:   rdata_r <= {16'h0000, drive_speed_r};
            ADDR_PULSES:  rdata_r <= pulse_cnt_r;
            ADDR_STATUS:  rdata_r <= {26'h000_0000, stop_req_r, cont_r, state_r};
            ADDR_SPEED:   rdata_r <= {16'h0000, speed_r};
            ADDR_EMITTED: rdata_r <= emitted_r;
            default:      rdata_r <= COUNT_RST;
         endcase
      end
   end

   assign reg_rdata_o   = rdata_r;
   assign drive_pulse_o = pulse_r;
   assign busy_o        = busy_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   sequence s_start_slow;
      (start_fixed || start_cont) && (drive_speed_r <= start_rate_r);
   endsequence

   sequence s_const_at_start;
      (state_r == ST_CONST) && (speed_r == $past(start_rate_r));
   endsequence

   property p_accel_rise;
      @(posedge clk_i) disable iff (reset_i)
      (state_r == ST_ACCEL) && ramp_tick && !top_reached && (state_nxt == ST_ACCEL)
      |=> speed_r == $past(speed_r) + 16'h0001;
   endproperty
   a_accel_rise: assert property (p_accel_rise) else $error("accel step wrong");

   property p_sym_dec;
      @(posedge clk_i) disable iff (reset_i)
      ((state_r == ST_ACCEL) || (state_r == ST_CONST)) && !cont_r && !manual_decel_select
      && !separate_decel_enable && (remain_r < acc_pulses_r) && !sstop && !last_pulse
      |=> state_r == ST_DECEL;
   endproperty
   a_sym_dec: assert property (p_sym_dec) else $error("no symmetric decel");

   property p_dec_fall;
      @(posedge clk_i) disable iff (reset_i)
      (state_r == ST_DECEL) && ramp_tick && (speed_r > start_rate_r) && !sstop
      |=> speed_r == $past(speed_r) - 16'h0001;
   endproperty
   a_dec_fall: assert property (p_dec_fall) else $error("decel step wrong");

   property p_fixed_end;
      @(posedge clk_i) disable iff (reset_i)
      last_pulse |=> (state_r == ST_IDLE) && drive_pulse_o ##1 !drive_pulse_o;
   endproperty
   a_fixed_end: assert property (p_fixed_end) else $error("fixed end wrong");

   property p_dstop_accel;
      @(posedge clk_i) disable iff (reset_i)
      (state_r == ST_ACCEL) && dstop && !sstop && !last_pulse |=> state_r == ST_DECEL;
   endproperty
   a_dstop_accel: assert property (p_dstop_accel) else $error("stop in accel lost");

   property p_dec_rate;
      @(posedge clk_i) disable iff (reset_i)
      (state_r == ST_DECEL) |-> ramp.incr == ({32'h0000_0000, separate_decel_enable ?
                                 decel_r : accel_r} * ACCEL_UNIT);
   endproperty
   a_dec_rate: assert property (p_dec_rate) else $error("decel slope wrong");

   property p_tri_hold;
      @(posedge clk_i) disable iff (reset_i)
      (state_r == ST_ACCEL) && tri_hold && !sstop && !last_pulse && !dstop && !auto_dec
      |=> (state_r == ST_CONST) && $stable(speed_r);
   endproperty
   a_tri_hold: assert property (p_tri_hold) else $error("triangle hold missed");

   property p_tri_reset;
      @(posedge clk_i) reset_i |=> !triangle_prevent_enable_r;
   endproperty
   a_tri_reset: assert property (p_tri_reset) else $error("triangle on after reset");

   property p_const_start;
      @(posedge clk_i) disable iff (reset_i)
      s_start_slow |=> s_const_at_start;
   endproperty
   a_const_start: assert property (p_const_start) else $error("no constant drive");

   property p_cont_runs;
      @(posedge clk_i) disable iff (reset_i)
      cont_r && (state_r == ST_CONST) && !sstop && !dstop |=> state_r == ST_CONST;
   endproperty
   a_cont_runs: assert property (p_cont_runs) else $error("continuous drive ended");

   property p_creep;
      @(posedge clk_i) disable iff (reset_i)
      (state_r == ST_DECEL) && (speed_r == start_rate_r) && !stop_req_r && !sstop
      && !last_pulse |=> (state_r == ST_DECEL) && (speed_r == $past(speed_r));
   endproperty
   a_creep: assert property (p_creep) else $error("creep speed left start rate");

endmodule // lap_profile_gen

// File: dv/lap_motor_model.sv
`timescale 1ns/10ps
// Stands in for the motor driver: counts step pulses and times the gaps between them.
module lap_motor_model (
   input  wire logic        clk_i,
   input  wire logic        clr_i,
   input  wire logic        pulse_i,
   output logic      [31:0] count_o,
   output logic      [31:0] gap_o,
   output logic      [31:0] min_gap_o
);
   logic [31:0] run_r;

   ////////////////////////////////////////////////////////////////////////////////
   // The first gap runs from the clear, so it is kept out of the minimum.
   always_ff @(posedge clk_i) begin
      if (clr_i) begin
         count_o   <= 32'h0;
         run_r     <= 32'h0;
         gap_o     <= 32'h0;
         min_gap_o <= 32'hFFFF_FFFF;
      end else if (pulse_i) begin
         count_o <= count_o + 32'h1;
         run_r   <= 32'h1;
         gap_o   <= run_r;
         if (count_o != 32'h0 && run_r < min_gap_o) begin
            min_gap_o <= run_r;
         end
      end else begin
         run_r <= run_r + 32'h1;
      end
   end
endmodule // lap_motor_model

// File: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import lap_pkg::*;
   logic        clk_i;
   logic        reset_i;
   logic [3:0]  reg_addr_i;
   logic [31:0] reg_wdata_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   logic [31:0] reg_rdata_o;
   logic        drive_pulse_o;
   logic        busy_o;
   logic        clr_r;
   logic        rd_seen_r;
   logic [31:0] cnt;
   logic [31:0] gap;
   logic [31:0] min_gap;
   logic [31:0] min_off;
   logic [31:0] seed;
   logic [31:0] npul;
   logic [31:0] exp_q[$];
   int          n_mismatch;
   int          n_tests;
   int          cyc;

   lap_profile_gen i_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .drive_pulse_o(drive_pulse_o), .busy_o(busy_o));
   lap_motor_model i_motor (.clk_i(clk_i), .clr_i(clr_r), .pulse_i(drive_pulse_o),
      .count_o(cnt), .gap_o(gap), .min_gap_o(min_gap));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Each access leaves one idle cycle so no strobe is assigned twice in a step.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i    <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_i);
      reg_rd_i   <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic go(input logic [31:0] m, input logic [31:0] srt, input logic [31:0] v,
                     input logic [31:0] p, input logic [31:0] cmd);
      wr(ADDR_MODE, m);
      wr(ADDR_START, srt);
      wr(ADDR_DRIVE, v);
      wr(ADDR_PULSES, p);
      clr_r <= 1'b1;
      @(posedge clk_i);
      clr_r <= 1'b0;
      wr(ADDR_CMD, cmd);
   endtask

   task automatic settle(input int lim);
      int i;
      i = 0;
      @(negedge clk_i);
      while (busy_o !== 1'b0 && i < lim) begin
         @(negedge clk_i);
         i++;
      end
      // The last pulse reaches the motor model one edge after busy falls.
      @(negedge clk_i);
      chk({31'h0, busy_o}, 32'h0);
      @(posedge clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Read data stand only in the cycle after the read strobe.
   always @(posedge clk_i) begin
      if (rd_seen_r) chk(reg_rdata_o, exp_q.pop_front());
      rd_seen_r <= reg_rd_i;
   end

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_mismatch++;
         summarize();
      end
   end

   initial begin
      reset_i = 1'b1;
      reg_addr_i = 4'h0;
      reg_wdata_i = 32'h0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      clr_r = 1'b1;
      rd_seen_r = 1'b0;
      n_mismatch = 0;
      n_tests = 0;
      cyc = 0;
      seed = 32'h0001_2CD2;
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      clr_r <= 1'b0;
      rd(ADDR_MODE, {29'h0, MODE_RST});
      rd(ADDR_EXT, 32'h0);
      rd(ADDR_RANGE, RANGE_RST);
      rd(ADDR_STATUS, 32'h1);
      rd(4'hF, 32'h0);
      wr(ADDR_STATUS, 32'hFF);
      rd(ADDR_STATUS, 32'h1);
      for (int k = 2; k < 8; k++) begin
         seed = lfsr(seed);
         wr(k[3:0], seed);
         rd(k[3:0], (k == 2 || k == 7) ? seed : {16'h0, seed[15:0]});
      end
      // Range 8000 makes one speed unit 1000 pulses per second: gap = 20000 / speed.
      wr(ADDR_RANGE, 32'h0000_1F40);
      wr(ADDR_ACCEL, 32'h0000_9C40);
      // A tiny deceleration value must be ignored in symmetric mode.
      wr(ADDR_DECEL, 32'h0000_0001);
      seed = lfsr(seed);
      npul = {28'h0, seed[3:0]} + 32'h4;
      go(32'h0, 32'h190, 32'h64, npul, 32'h1);
      settle(3000);
      chk(cnt, npul);
      chk({31'h0, gap >= 32'h31 && gap <= 32'h33}, 32'h1);
      rd(ADDR_EMITTED, npul);
      go(32'h0, 32'h64, 32'h3E8, 32'h190, 32'h1);
      rd(ADDR_STATUS, 32'h2);
      settle(30000);
      chk({31'h0, busy_o}, 32'h0);
      chk(cnt, 32'h190);
      chk({31'h0, min_gap >= 32'h13 && min_gap <= 32'h15}, 32'h1);
      chk({31'h0, gap >= 32'h50}, 32'h1);
      go(32'h0, 32'h64, 32'h1388, 32'h190, 32'h1);
      settle(30000);
      min_off = min_gap;
      chk(cnt, 32'h190);
      wr(ADDR_EXT, 32'h8);
      rd(ADDR_EXT, 32'h8);
      go(32'h0, 32'h64, 32'h1388, 32'h190, 32'h1);
      settle(30000);
      chk({31'h0, min_gap > min_off}, 32'h1);
      wr(ADDR_EXT, 32'h0);
      wr(ADDR_DECEL, 32'h0000_FFFF);
      go(32'h2, 32'h64, 32'h3E8, 32'h190, 32'h1);
      settle(30000);
      chk(cnt, 32'h190);
      chk({31'h0, gap >= 32'h50}, 32'h1);
      go(32'h1, 32'h64, 32'h3E8, 32'h190, 32'h1);
      settle(30000);
      chk(cnt, 32'h190);
      chk(gap, 32'h14);
      go(32'h0, 32'h64, 32'h3E8, 32'h0, 32'h2);
      rd(ADDR_STATUS, 32'h12);
      repeat (300) @(posedge clk_i);
      chk({31'h0, busy_o}, 32'h1);
      wr(ADDR_CMD, 32'h4);
      settle(3000);
      chk({31'h0, busy_o}, 32'h0);
      chk({31'h0, gap >= 32'h80}, 32'h1);
      go(32'h0, 32'h64, 32'h64, 32'h0, 32'h2);
      repeat (200) @(posedge clk_i);
      wr(ADDR_CMD, 32'h8);
      @(negedge clk_i);
      chk({31'h0, busy_o}, 32'h0);
      @(posedge clk_i);
      wr(ADDR_ACCEL, 32'h0000_0001);
      go(32'h0, 32'h64, 32'h3E8, 32'h4, 32'h1);
      settle(3000);
      chk(cnt, 32'h4);
      chk(gap, 32'hC8);
      summarize();
   end
endmodule // tb_top
